// ==== verilog/asp_serial_port.sv ====
// Serial port zero: full-duplex asynchronous port with baud generation
// Operation
// [R1] Full-duplex asynchronous port, classic modes 1 and 3, variable baud
// [R2] Received byte buffered so the next reception can start before read
// [R3] Data buffer write loads transmit holding register and starts sending
// [R4] Data buffer read returns buffered receive data, never transmit data
// [R5] Interrupt request whenever transmit or receive done flag sets, if enabled
// [R6] Flags never cleared by hardware; software clears each explicitly
// [R7] Transmit bit clock from overflows of 8-bit auto-reload timer low byte
// [R8] Hidden receive copy of timer runs with timer, same reload byte
// [R9] Transmit and receive timer overflows each divided by two
// [R10] Start edge on receive line forces reload of receive timer copy
// [R11] Software picks timer mode 2 and reload for twice baud frequency
// [R12] Timer clocked from six selectable sources
// [R13] Overflow rate is timer clock over 256 minus reload; baud half that
// [R14] System clock may stay internal while external oscillator drives timer
// [R15] 8-bit frame: start, eight data bits LSB first, stop
// [R16] 9-bit frame: start, eight data LSB first, ninth bit, stop
// [R17] Transmit done flag sets at the start of the stop bit
// [R18] Byte loaded only if receive flag clear and check bit passes
module asp_serial_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic frame_mode_select,
  input wire logic multiproc_check_enable,
  input wire logic receive_enable,
  input wire logic transmit_ninth_bit,
  input wire logic serial_int_enable,
  input wire logic timer_run,
  input wire logic [2:0] timer_clk_select,
  input wire logic ext_osc_tick,
  input wire logic timer_ext_input,
  input wire logic reload_write,
  input wire logic [7:0] reload_wdata,
  input wire logic data_write,
  input wire logic [7:0] data_wdata,
  input wire logic data_read,
  input wire logic transmit_done_clear,
  input wire logic receive_done_clear,
  input wire logic rx_line,
  output logic tx_line,
  output logic [7:0] serial_data_buffer,
  output logic received_ninth_bit,
  output logic transmit_done_flag,
  output logic receive_done_flag,
  output logic serial_irq,
  output logic tx_busy,
  output logic [7:0] timer_reload_byte,
  output logic [7:0] timer_low_byte
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} asp_rx_state_t;

  // ==========================================================================
  // Baud generation
  logic tx_baud_tick;
  logic rx_baud_tick;
  logic rx_half_tick;
  logic rx_start_seen;
  logic [7:0] tmr_low;

  asp_baud u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .timer_run(timer_run),
    .clk_src_sel(timer_clk_select),
    .ext_osc_tick(ext_osc_tick),
    .timer_ext_input(timer_ext_input),
    .timer_reload_byte(timer_reload_byte),
    .rx_force_reload(rx_start_seen),
    .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick),
    .rx_half_tick(rx_half_tick),
    .timer_low_byte(tmr_low)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_reload_byte <= asp_pkg::RELOAD_RESET;
      timer_low_byte <= asp_pkg::TIMER_RESET;
    end else begin
      if (reload_write) begin
        timer_reload_byte <= reload_wdata; // R11
      end
      timer_low_byte <= tmr_low;
    end
  end

  // ==========================================================================
  // Transmitter: a write to the data buffer loads and starts a frame
  logic [10:0] tx_shift_reg;
  logic [3:0] tx_count_reg;
  logic [3:0] tx_last;
  logic tx_set;

  assign tx_last = frame_mode_select ? asp_pkg::BIT_LAST9 : asp_pkg::BIT_LAST8; // R1
  // Flag rises on the tick that puts the stop bit on the line, not one bit earlier
  assign tx_set = tx_busy && tx_baud_tick && (tx_count_reg == tx_last); // R17

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_shift_reg <= 11'h7FF;
      tx_count_reg <= 4'h0;
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
    end else if (data_write) begin
      // A write during a frame restarts it with the new byte
      tx_shift_reg <= {1'b1, frame_mode_select ? transmit_ninth_bit : 1'b1,
                       data_wdata, 1'b0}; // R3 R15 R16
      tx_count_reg <= 4'h0;
      tx_busy <= 1'b1;
    end else if (tx_busy && tx_baud_tick) begin
      tx_line <= tx_shift_reg[0]; // R15 R16
      tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
      if (tx_count_reg == tx_last + 4'h1) begin
        tx_busy <= 1'b0;
        tx_line <= 1'b1;
      end else begin
        tx_count_reg <= tx_count_reg + 4'h1;
      end
    end
  end

  // ==========================================================================
  // Receiver: samples mid-bit on the receive timer copy
  asp_rx_state_t rx_state_reg;
  logic rx_line_d_reg;
  logic [9:0] rx_shift_reg;
  logic [3:0] rx_count_reg;
  logic rx_done;
  logic rx_accept;
  logic rx_check_bit;
  logic rx_sample;

  assign rx_start_seen = receive_enable && (rx_state_reg == RX_IDLE)
                         && rx_line_d_reg && !rx_line; // R10
  assign rx_sample = rx_half_tick;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_line_d_reg <= 1'b1;
      rx_shift_reg <= 10'h000;
      rx_count_reg <= 4'h0;
    end else begin
      rx_line_d_reg <= rx_line;
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_start_seen) begin
            rx_state_reg <= RX_START;
            rx_count_reg <= 4'h0;
          end
        end
        RX_START: begin
          if (rx_sample) begin
            rx_state_reg <= rx_line ? RX_IDLE : RX_BITS; // False start rejected
          end
        end
        RX_BITS: begin
          if (rx_sample) begin
            rx_shift_reg <= {rx_line, rx_shift_reg[9:1]}; // R15 R16
            rx_count_reg <= rx_count_reg + 4'h1;
            if (rx_count_reg == tx_last - 4'h1) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  assign rx_done = (rx_state_reg == RX_BITS) && rx_sample && (rx_count_reg == tx_last - 4'h1);

  // Word in the cycle of the final sample, which is still on the line.
  // 8-bit: the final sample is the stop bit, kept as the ninth bit.
  // 9-bit: the ninth bit was shifted in one bit earlier; the stop bit is ignored.
  asp_pkg::asp_word_t rx_final;
  always_comb begin
    if (frame_mode_select) begin
      rx_final.data = rx_shift_reg[8:1]; // R16
      rx_final.ninth = rx_shift_reg[9];
    end else begin
      rx_final.data = rx_shift_reg[9:2]; // R15
      rx_final.ninth = rx_line;
    end
    rx_check_bit = rx_final.ninth; // R18
  end

  // Buffer between the shifter and the readable holding register
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  asp_pkg::asp_word_t buf_out_word;

  // Holding register accepts only while receive flag is clear; a word arriving while
  // both entries are full is dropped, the overrun loss software must expect
  assign rx_accept = rx_done && (!multiproc_check_enable || rx_check_bit); // R18
  assign buf_out_ready = !receive_done_flag; // R18

  asp_buf2 u_rx_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rx_accept),
    .in_ready(buf_in_ready),
    .in_word(rx_final),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_word(buf_out_word)
  );

  logic rx_load;
  assign rx_load = buf_out_valid && buf_out_ready;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_data_buffer <= asp_pkg::DATA_RESET;
      received_ninth_bit <= 1'b0;
    end else if (rx_load) begin
      serial_data_buffer <= buf_out_word.data; // R2 R4
      received_ninth_bit <= buf_out_word.ninth;
    end
  end

  // ==========================================================================
  // Flags: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag <= 1'b0;
      serial_irq <= 1'b0;
    end else begin
      if (tx_set) begin
        transmit_done_flag <= 1'b1; // R17
      end else if (transmit_done_clear) begin
        transmit_done_flag <= 1'b0; // R6
      end
      if (rx_load) begin
        receive_done_flag <= 1'b1; // R18
      end else if (receive_done_clear) begin
        receive_done_flag <= 1'b0; // R6
      end
      serial_irq <= serial_int_enable && (transmit_done_flag || receive_done_flag
                    || tx_set || rx_load); // R5
    end
  end

  // ==========================================================================
  // Assertions
  AST_TX_START_BIT: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (tx_busy && tx_baud_tick && !data_write && tx_count_reg == 4'h0) |=> !tx_line)
    else $error("start bit not low");
  AST_TX_FLAG_SET: assert property (@(posedge sys_clk) disable iff (rst) // R17
    tx_set |=> transmit_done_flag)
    else $error("transmit flag not set");
  AST_RX_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (receive_done_flag && !receive_done_clear) |=> receive_done_flag)
    else $error("receive flag cleared by hardware");
  AST_TX_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // R6
    (transmit_done_flag && !transmit_done_clear) |=> transmit_done_flag)
    else $error("transmit flag cleared by hardware");
  AST_RX_LOAD_GATE: assert property (@(posedge sys_clk) disable iff (rst) // R18
    (receive_done_flag && !receive_done_clear) |=> $stable(serial_data_buffer))
    else $error("receive data changed while flag set");
  AST_IRQ: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (serial_int_enable && receive_done_flag) |=> serial_irq)
    else $error("interrupt missing");
  AST_IRQ_OFF: assert property (@(posedge sys_clk) disable iff (rst) // R5
    !serial_int_enable |=> !serial_irq)
    else $error("interrupt while disabled");
  AST_TX_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst) // R15
    !tx_busy |-> tx_line)
    else $error("line low while idle");
  AST_MCE_DROP: assert property (@(posedge sys_clk) disable iff (rst) // R18
    (rx_done && multiproc_check_enable && !(frame_mode_select ? rx_shift_reg[9] : rx_line))
    |-> !rx_accept)
    else $error("rejected byte accepted");
  AST_TX_WRITE_HIDDEN: assert property (@(posedge sys_clk) disable iff (rst) // R4
    (data_write && !rx_load) |=> $stable(serial_data_buffer))
    else $error("transmit data visible on read side");
  AST_TX_STOP: assert property (@(posedge sys_clk) disable iff (rst) // R17
    tx_set |=> tx_line)
    else $error("transmit flag not at stop bit");
  AST_TX_FRAME_END: assert property (@(posedge sys_clk) disable iff (rst) // R15
    (tx_busy && tx_baud_tick && !data_write && tx_count_reg == tx_last + 4'h1)
    |=> (!tx_busy && tx_line))
    else $error("frame not ended after stop bit");
  AST_RX_FLAG_SET: assert property (@(posedge sys_clk) disable iff (rst) // R2
    rx_load |=> (receive_done_flag && serial_data_buffer == $past(buf_out_word.data)))
    else $error("buffered word not loaded");
  AST_RX_START: assert property (@(posedge sys_clk) disable iff (rst) // R10
    rx_start_seen |=> (rx_state_reg == RX_START))
    else $error("start edge not taken");
  AST_IRQ_TX: assert property (@(posedge sys_clk) disable iff (rst) // R5
    (serial_int_enable && tx_set) |=> serial_irq)
    else $error("transmit interrupt missing");

  COV_TX_DONE: cover property (@(posedge sys_clk) tx_set);
  COV_RX_LOAD: cover property (@(posedge sys_clk) rx_load);
  COV_RX_HELD: cover property (@(posedge sys_clk) !buf_in_ready && receive_done_flag);
  COV_READ: cover property (@(posedge sys_clk) data_read && receive_done_flag);
  COV_NINE: cover property (@(posedge sys_clk) rx_load && frame_mode_select);

endmodule : asp_serial_port

// ==== verilog/asp_pkg.sv ====
// Package: constants and carrier types for the serial port with baud generator
package asp_pkg;

  // ==========================================================================
  // Frame and timer constants
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned TIMER_SPAN = 256;
  localparam int unsigned OVF_PER_BIT = 2;
  localparam int unsigned DIV4 = 4;
  localparam int unsigned DIV12 = 12;
  localparam int unsigned DIV48 = 48;
  localparam int unsigned EXT_OSC_DIV = 8;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] TIMER_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [3:0] BIT_LAST8 = 4'h9;
  localparam logic [3:0] BIT_LAST9 = 4'hA;

  // ==========================================================================
  // Timer clock sources
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_DIV4 = 3'h1;
  localparam logic [2:0] SRC_DIV12 = 3'h2;
  localparam logic [2:0] SRC_DIV48 = 3'h3;
  localparam logic [2:0] SRC_EXT_OSC = 3'h4;
  localparam logic [2:0] SRC_EXT_IN = 3'h5;

  // ==========================================================================
  // Types
  typedef enum logic {ASP_MODE_8BIT, ASP_MODE_9BIT} asp_mode_t;

  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } asp_word_t;

endpackage : asp_pkg

// ==== verilog/asp_buf2.sv ====
// Two-entry buffer with valid and ready on both sides
module asp_buf2 (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire asp_pkg::asp_word_t in_word,
  output logic out_valid,
  input wire logic out_ready,
  output asp_pkg::asp_word_t out_word
);

  asp_pkg::asp_word_t mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_word = mem_reg[rd_ptr_reg];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_word;
    end
  end

  AST_BUF_NO_OVERFLOW: assert property (@(posedge sys_clk) disable iff (rst)
    count_reg <= 2'h2)
    else $error("buffer count above two");

endmodule : asp_buf2

// ==== verilog/asp_baud.sv ====
// Timer with auto-reload, receive copy and divide-by-two baud enables
module asp_baud (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic timer_run,
  input wire logic [2:0] clk_src_sel,
  input wire logic ext_osc_tick,
  input wire logic timer_ext_input,
  input wire logic [7:0] timer_reload_byte,
  input wire logic rx_force_reload,
  output logic tx_baud_tick,
  output logic rx_baud_tick,
  output logic rx_half_tick,
  output logic [7:0] timer_low_byte
);

  logic [5:0] pre_reg;
  logic [2:0] osc_cnt_reg;
  logic ext_in_d_reg;
  logic src_tick;
  logic [7:0] tx_cnt_reg;
  logic [7:0] rx_cnt_reg;
  logic tx_half_reg;
  logic rx_half_reg;
  logic tx_ovf;
  logic rx_ovf;

  function automatic logic div_hit(input logic [5:0] cnt, input int unsigned div);
    div_hit = (cnt % 6'(div)) == 6'h00;
  endfunction : div_hit

  // Six clock sources; the external oscillator arrives as a tick so the
  // system clock can stay on the internal oscillator while it drives the timer
  always_comb begin
    case (clk_src_sel)
      asp_pkg::SRC_SYS: src_tick = 1'b1; // R12 R14
      asp_pkg::SRC_DIV4: src_tick = div_hit(pre_reg, asp_pkg::DIV4);
      asp_pkg::SRC_DIV12: src_tick = div_hit(pre_reg, asp_pkg::DIV12);
      asp_pkg::SRC_DIV48: src_tick = (pre_reg == 6'h00);
      asp_pkg::SRC_EXT_OSC: src_tick = ext_osc_tick && (osc_cnt_reg == 3'h0);
      asp_pkg::SRC_EXT_IN: src_tick = timer_ext_input && !ext_in_d_reg;
      default: src_tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_reg <= 6'h00;
      osc_cnt_reg <= 3'h0;
      ext_in_d_reg <= 1'b0;
    end else begin
      pre_reg <= (pre_reg == 6'(asp_pkg::DIV48 - 1)) ? 6'h00 : pre_reg + 6'h01;
      if (ext_osc_tick) begin
        osc_cnt_reg <= osc_cnt_reg + 3'h1;
      end
      ext_in_d_reg <= timer_ext_input;
    end
  end

  assign tx_ovf = timer_run && src_tick && (tx_cnt_reg == 8'hFF);
  assign rx_ovf = timer_run && src_tick && (rx_cnt_reg == 8'hFF);

  // Overflow rate is source / (256 - reload)
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_cnt_reg <= asp_pkg::TIMER_RESET;
      rx_cnt_reg <= asp_pkg::TIMER_RESET;
    end else begin
      if (timer_run && src_tick) begin
        tx_cnt_reg <= tx_ovf ? timer_reload_byte : tx_cnt_reg + 8'h01; // R7 R13
      end
      if (rx_force_reload) begin
        rx_cnt_reg <= timer_reload_byte; // R10
      end else if (timer_run && src_tick) begin
        rx_cnt_reg <= rx_ovf ? timer_reload_byte : rx_cnt_reg + 8'h01; // R8
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_half_reg <= 1'b0;
      rx_half_reg <= 1'b0;
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
      rx_half_tick <= 1'b0;
    end else begin
      if (tx_ovf) begin
        tx_half_reg <= ~tx_half_reg; // R9
      end
      if (rx_force_reload) begin
        rx_half_reg <= 1'b0;
      end else if (rx_ovf) begin
        rx_half_reg <= ~rx_half_reg; // R9
      end
      tx_baud_tick <= tx_ovf && tx_half_reg; // R13
      rx_baud_tick <= rx_ovf && rx_half_reg && !rx_force_reload;
      rx_half_tick <= rx_ovf && !rx_half_reg && !rx_force_reload;
    end
  end

  assign timer_low_byte = tx_cnt_reg;

  AST_RX_RELOAD: assert property (@(posedge sys_clk) disable iff (rst)
    rx_force_reload |=> rx_cnt_reg == $past(timer_reload_byte)) // R10
    else $error("receive timer not reloaded on start");

endmodule : asp_baud

// ==== testbench/asp_remote.sv ====
// Remote serial transceiver model facing the serial port lines
module asp_remote (
  input wire logic sys_clk,
  input wire logic tx_line,
  output logic rx_line
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_cyc = 16;
  logic nine = 1'b0;
  logic [8:0] got = 9'h000;
  initial rx_line = 1'b1;

  // ==========================================================================
  // Sender: whole frame, line returns to its pulled-up idle level after
  task automatic send(input logic [7:0] d, input logic b9, input logic stop);
    logic [10:0] f;
    f = nine ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge sys_clk);
      #1 rx_line = f[i];
      repeat (bit_cyc - 1) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1 rx_line = 1'b1;
  endtask : send

  // ==========================================================================
  // Receiver: samples bit centres, LSB first, ninth bit in 9-bit frames
  always begin
    @(negedge tx_line);
    repeat (bit_cyc / 2) @(posedge sys_clk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_cyc) @(posedge sys_clk);
      got[i] = tx_line;
    end
    repeat (bit_cyc) @(posedge sys_clk);
  end
endmodule : asp_remote

// ==== testbench/async_serial_port_baud_gen_test.sv ====
// Self-checking bench for the serial port with baud generator
module async_serial_port_baud_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic mode = 1'b0, mce = 1'b0, ren = 1'b1, tb9 = 1'b0, ien = 1'b1, run = 1'b0;
  logic [2:0] sel = 3'h0;
  logic osc = 1'b1, ext_in = 1'b0, rl_wr = 1'b0, d_wr = 1'b0, d_rd = 1'b0;
  logic [7:0] rl_d = 8'hF8, d_d = 8'h00;
  logic txc = 1'b0, rxc = 1'b0, rx_line, tx_line, rb9, txf, rxf, irq, busy;
  logic [7:0] sbuf, rl_q, tl_q;
  int error_cnt = 0;
  int n_checks = 0;

  always #4 sys_clk = ~sys_clk;
  // Rising edge every second cycle on the external timer input
  always @(posedge sys_clk) #1 ext_in = ~ext_in;

  asp_remote p (.sys_clk(sys_clk), .tx_line(tx_line), .rx_line(rx_line));

  asp_serial_port DUT (.sys_clk(sys_clk), .rst(rst), .frame_mode_select(mode),
    .multiproc_check_enable(mce), .receive_enable(ren), .transmit_ninth_bit(tb9),
    .serial_int_enable(ien), .timer_run(run), .timer_clk_select(sel),
    .ext_osc_tick(osc), .timer_ext_input(ext_in), .reload_write(rl_wr),
    .reload_wdata(rl_d), .data_write(d_wr), .data_wdata(d_d), .data_read(d_rd),
    .transmit_done_clear(txc), .receive_done_clear(rxc), .rx_line(rx_line),
    .tx_line(tx_line), .serial_data_buffer(sbuf), .received_ninth_bit(rb9),
    .transmit_done_flag(txf), .receive_done_flag(rxf), .serial_irq(irq),
    .tx_busy(busy), .timer_reload_byte(rl_q), .timer_low_byte(tl_q));

  // ==========================================================================
  // Shared helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic write_byte(input logic [7:0] d, input logic b9);
    d_d = d;
    tb9 = b9;
    d_wr = 1'b1;
    tick(1);
    d_wr = 1'b0;
  endtask : write_byte

  task automatic clear_rx();
    rxc = 1'b1;
    d_rd = 1'b1;
    tick(1);
    rxc = 1'b0;
    d_rd = 1'b0;
    tick(2);
  endtask : clear_rx

  // Waits for the transmit flag, returns cycles from start bit to flag
  task automatic send_wait(input logic [7:0] d, input logic b9, output int c);
    int w;
    w = 0;
    c = 0;
    write_byte(d, b9);
    while (tx_line !== 1'b0 && w < 2000) begin
      tick(1);
      w++;
    end
    while (txf !== 1'b1 && c < 10000) begin
      tick(1);
      c++;
    end
    chk(txf, 1'b1);
  endtask : send_wait

  // ==========================================================================
  // Scenarios
  task automatic t_baud();
    int mul[6] = '{1, 4, 12, 48, 8, 2};
    int c;
    for (int s = 0; s < 6; s++) begin
      sel = 3'(s);
      p.bit_cyc = mul[s] * 16;
      write_byte(8'hFF, 1'b0);
      c = 0;
      while (tx_line !== 1'b0 && c < 2000) begin
        tick(1);
        c++;
      end
      c = 0;
      while (tx_line === 1'b0 && c < 2000) begin
        tick(1);
        c++;
      end
      chk(c, mul[s] * 2 * (256 - 248));
      // Next write only once the frame in flight has raised its flag
      c = 0;
      while (txf !== 1'b1 && c < 10000) begin
        tick(1);
        c++;
      end
      chk(txf, 1'b1);
      txc = 1'b1;
      tick(1);
      txc = 1'b0;
      send_wait(8'h00, 1'b0, c);
      txc = 1'b1;
      tick(1);
      txc = 1'b0;
      tick(p.bit_cyc * 3);
      chk(p.got[7:0], 8'h00);
    end
    sel = 3'h0;
    p.bit_cyc = 16;
  endtask : t_baud

  task automatic t_tx8();
    int c;
    send_wait(8'h5A, 1'b1, c);
    chk(busy, 1'b1);
    chk(c >= 143 && c <= 146, 1'b1);
    chk(tx_line, 1'b1);
    tick(2);
    chk(irq, 1'b1);
    tick(60);
    chk(p.got[7:0], 8'h5A);
    chk(busy, 1'b0);
    chk(tl_q >= 8'hF8, 1'b1);
    chk(txf, 1'b1);
    txc = 1'b1;
    tick(1);
    txc = 1'b0;
    tick(2);
    chk({txf, irq}, 2'b00);
  endtask : t_tx8

  task automatic t_tx9();
    int c;
    mode = 1'b1;
    p.nine = 1'b1;
    send_wait(8'hA5, 1'b1, c);
    chk(c >= 159 && c <= 162, 1'b1);
    tick(60);
    chk(p.got, 9'h1A5);
    txc = 1'b1;
    tick(1);
    txc = 1'b0;
    mode = 1'b0;
    p.nine = 1'b0;
  endtask : t_tx9

  task automatic t_rx8();
    p.send(8'h3C, 1'b0, 1'b1);
    tick(2);
    chk({rxf, rb9, sbuf}, {2'b11, 8'h3C});
    chk(irq, 1'b1);
    p.send(8'hC3, 1'b0, 1'b1);
    chk(sbuf, 8'h3C);
    clear_rx();
    chk({rxf, sbuf}, {1'b1, 8'hC3});
    p.send(8'h11, 1'b0, 1'b1);
    p.send(8'h22, 1'b0, 1'b1);
    p.send(8'h33, 1'b0, 1'b1);
    clear_rx();
    chk({rxf, sbuf}, {1'b1, 8'h11});
    clear_rx();
    chk({rxf, sbuf}, {1'b1, 8'h22});
    clear_rx();
    tick(4);
    chk(rxf, 1'b0);
    ien = 1'b0;
    p.send(8'h44, 1'b0, 1'b1);
    tick(2);
    chk({rxf, irq, sbuf}, {2'b10, 8'h44});
    clear_rx();
    ien = 1'b1;
  endtask : t_rx8

  task automatic t_mce();
    mce = 1'b1;
    p.send(8'h77, 1'b0, 1'b0);
    tick(40);
    chk({rxf, sbuf}, {1'b0, 8'h44});
    mode = 1'b1;
    p.nine = 1'b1;
    p.send(8'h66, 1'b0, 1'b1);
    tick(2);
    chk(rxf, 1'b0);
    p.send(8'h99, 1'b1, 1'b1);
    tick(2);
    chk({rxf, rb9, sbuf}, {2'b11, 8'h99});
    clear_rx();
    mce = 1'b0;
    p.send(8'h0F, 1'b0, 1'b1);
    tick(2);
    chk({rxf, rb9, sbuf}, {2'b10, 8'h0F});
    clear_rx();
    mode = 1'b0;
    p.nine = 1'b0;
  endtask : t_mce

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    tick(8);
    rst = 1'b0;
    rl_wr = 1'b1;
    tick(1);
    rl_wr = 1'b0;
    run = 1'b1;
    tick(1);
    chk(rl_q, 8'hF8);
    t_tx8();
    t_tx9();
    t_rx8();
    t_mce();
    t_baud();
    give_verdict();
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    give_verdict();
  end
endmodule : async_serial_port_baud_gen_test
